// File: logic/spi_cfg_defines.vh
// constants shared by the serial port configuration block
`ifndef SPI_CFG_DEFINES_VH
`define SPI_CFG_DEFINES_VH
// register byte offsets
`define OFS_CTRL 5'h00
`define OFS_TXDATA 5'h04
`define OFS_RXDATA 5'h08
`define OFS_STATUS 5'h0C
`define OFS_CLKDIV 5'h10
// control register bit positions
`define B_SAMPLE_PHASE 9
`define B_CKE 8
`define B_SEL_EN 7
`define B_IDLE_POL 6
`define B_MST 5
// implemented control bits, 15..13 read as zero
`define CTRL_MASK 16'h1FFF
`define CTRL_RESET 16'h0000
// clock divider, half period is value plus one system clocks
`define CLKDIV_RESET 8'h03
// synchroniser reset levels {select, data, clock}: select idle high, clock idle low
`define SYNC_IDLE_BITS 3'h6
// status bit positions
`define S_BUSY 0
`define S_FULL 1
`define S_EMPTY 2
`define S_RXFULL 3
`define S_OVR 4
// transfer geometry, eight bits gives sixteen clock edges
`define STEP_LAST 5'h10
`define STEP_LASTTRAIL 5'h0F
`define STEP_ZERO 5'h00
`define BIT_LAST 3'h7
`define BIT_ZERO 3'h0
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h00000000
`endif

// File: logic/spi_clock_phase_mode_config.v
// serial port with clock polarity, edge and sample phase configuration
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "spi_cfg_defines.vh"

// small flop fifo, valid/ready on both sides
module fifo_buf #(
   parameter W = 8,
   parameter D = 4,
   parameter AW = 2
) (
   input wire clk,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:D-1]; // storage entries
   reg [AW-1:0] wp_reg; // write index
   reg [AW-1:0] rp_reg; // read index
   reg [AW:0] cnt_reg; // fill level
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_reg != D[AW:0]);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign out_data = mem[rp_reg];

   // pointers and level; push and pop may share a cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_reg <= {AW{1'b0}};
         rp_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) wp_reg <= wp_reg + 1'b1;
         if (pop) rp_reg <= rp_reg + 1'b1;
         if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
         else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // data entries are not reset, only read while valid
   always @(posedge clk) begin
      if (push) mem[wp_reg] <= in_data;
   end
endmodule

// top: avalon slave, tx fifo, master and slave shifter
module spi_clock_phase_mode_config (
   input wire clk,
   input wire rst_n,
   input wire [4:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest,
   output reg sck_out,
   output reg sck_oe,
   input wire sck_in,
   output reg sdo_out,
   output reg sdo_oe,
   input wire sdi_in,
   input wire slave_select_pin_n,
   output reg slave_select_pin_owned
);
   reg [15:0] ctrl_reg; // control word
   reg [7:0] div_reg; // half period minus one
   reg [2:0] sync1_reg; // first sync stage, read only by stage two
   reg [2:0] sync2_reg; // synchronised pins
   reg sck_prev_reg; // last synced clock level
   reg busy_reg; // master transfer running
   reg [4:0] step_reg; // master half period index
   reg [7:0] dcnt_reg; // divider count
   reg [7:0] tx_sh_reg; // outgoing bits
   reg [7:0] rx_sh_reg; // incoming bits
   reg [2:0] bit_reg; // slave sample count
   reg loaded_reg; // slave shifter holds a byte
   reg [7:0] rx_data_reg; // last received byte
   reg rx_full_reg; // unread byte present
   reg ovr_reg; // byte arrived while full
   wire [2:0] pins_raw = {slave_select_pin_n, sdi_in, sck_in};
   wire sck_s = sync2_reg[0];
   wire sdi_s = sync2_reg[1];
   wire ss_n_s = sync2_reg[2];
   wire sample_late = ctrl_reg[`B_SAMPLE_PHASE]; // input sample phase
   wire cke = ctrl_reg[`B_CKE];
   wire sel_en = ctrl_reg[`B_SEL_EN]; // slave select enable
   wire cpol = ctrl_reg[`B_IDLE_POL]; // clock idle polarity
   wire mst = ctrl_reg[`B_MST];
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;

   // reset to the idle pin levels so no false clock edge follows reset
   localparam [2:0] SYNC_IDLE = `SYNC_IDLE_BITS;

   // two flop synchronisers, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               sync1_reg[gi] <= SYNC_IDLE[gi];
               sync2_reg[gi] <= SYNC_IDLE[gi];
            end else begin
               sync1_reg[gi] <= pins_raw[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   // bus decode
   wire req = read || write;
   wire is_tx = (address == `OFS_TXDATA);
   wire is_rx = (address == `OFS_RXDATA);
   // tx write stalls while the fifo is full, that is the back-pressure
   wire wr_ok = !(write && is_tx && !fifo_in_ready);
   wire take = waitrequest && req && wr_ok;
   wire tx_push = take && write && is_tx;
   wire rx_read = take && read && is_rx;

   // master timing; edge index even is idle-to-active, odd is back to idle
   wire tick = busy_reg && (dcnt_reg == div_reg);
   wire at_end = (step_reg == `STEP_LAST);
   wire m_lead = tick && !step_reg[0] && !at_end;
   wire m_trail = tick && step_reg[0];

   // slave edges relative to the idle level
   wire s_lead = (sck_prev_reg == cpol) && (sck_s != cpol);
   wire s_trail = (sck_prev_reg != cpol) && (sck_s == cpol);
   wire slave_sel = sel_en ? !ss_n_s : 1'b1;
   wire s_act = !mst && slave_sel && loaded_reg;

   // output change edge
   wire m_chg = cke ? (m_trail && step_reg != `STEP_LASTTRAIL) : m_lead;
   // slave with edge bit set: the trailing edge after the eighth sample ends
   // the byte, it must not shift the freshly loaded next byte
   wire s_chg = cke ? (s_trail && bit_reg != `BIT_ZERO) : s_lead;
   wire do_chg = mst ? m_chg : (s_act && s_chg);
   // input sample point; slave always samples mid bit
   wire m_end = cke ? m_trail : ((m_lead && step_reg != `STEP_ZERO) || (tick && at_end));
   wire m_mid = cke ? m_lead : m_trail;
   wire m_sample = sample_late ? m_end : m_mid;
   wire do_sample = mst ? m_sample : (s_act && (cke ? s_lead : s_trail));
   wire done = mst ? (tick && at_end) : (do_sample && bit_reg == `BIT_LAST);
   wire [7:0] rx_word = do_sample ? {rx_sh_reg[6:0], sdi_s} : rx_sh_reg;

   // shifter loads: master on start, slave whenever empty
   wire m_start = mst && !busy_reg && fifo_out_valid;
   wire s_load = !mst && !loaded_reg;
   wire pop = m_start || (s_load && fifo_out_valid);
   // an empty fifo lets the slave answer with zeros
   wire [7:0] load_data = fifo_out_valid ? fifo_out_data : `BYTE_ZERO;
   wire load = m_start || s_load;

   fifo_buf #(.W(8), .D(4), .AW(2)) u_txq (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(tx_push),
      .in_ready(fifo_in_ready),
      .in_data(writedata[7:0]),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(fifo_out_data)
   );

   // bus slave: one wait cycle, answer on the next edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
         readdata <= `WORD_ZERO;
         ctrl_reg <= `CTRL_RESET;
         div_reg <= `CLKDIV_RESET;
      end else if (!waitrequest) begin
         waitrequest <= 1'b1; // release after the answer edge
      end else if (take) begin
         waitrequest <= 1'b0;
         readdata <= `WORD_ZERO;
         if (write) begin
            if (address == `OFS_CTRL) ctrl_reg <= writedata[15:0] & `CTRL_MASK;
            if (address == `OFS_CLKDIV) div_reg <= writedata[7:0];
         end else begin
            case (address)
               `OFS_CTRL: readdata <= {16'h0000, ctrl_reg};
               `OFS_RXDATA: readdata <= {24'h000000, rx_data_reg};
               `OFS_CLKDIV: readdata <= {24'h000000, div_reg};
               `OFS_STATUS: begin
                  readdata[`S_BUSY] <= busy_reg || (bit_reg != `BIT_ZERO);
                  readdata[`S_FULL] <= !fifo_in_ready;
                  readdata[`S_EMPTY] <= !fifo_out_valid;
                  readdata[`S_RXFULL] <= rx_full_reg;
                  readdata[`S_OVR] <= ovr_reg;
               end
               default: readdata <= `WORD_ZERO; // unmapped reads zero
            endcase
         end
      end
   end

   // master sequencer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
         step_reg <= `STEP_ZERO;
         dcnt_reg <= `BYTE_ZERO;
      end else if (m_start) begin
         busy_reg <= 1'b1;
         step_reg <= `STEP_ZERO;
         dcnt_reg <= `BYTE_ZERO;
      end else if (busy_reg) begin
         if (tick) begin
            dcnt_reg <= `BYTE_ZERO;
            if (at_end) busy_reg <= 1'b0;
            else step_reg <= step_reg + 1'b1;
         end else begin
            dcnt_reg <= dcnt_reg + 1'b1;
         end
      end
   end

   // pin drivers
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_out <= 1'b0;
         sck_oe <= 1'b0;
         sdo_oe <= 1'b0;
         slave_select_pin_owned <= 1'b0;
         sck_prev_reg <= 1'b0; // matches the synced clock reset level
      end else begin
         sck_prev_reg <= sck_s;
         sck_oe <= mst;
         // slave drives data while selected, or always with select disabled
         sdo_oe <= mst || slave_sel;
         slave_select_pin_owned <= !mst && sel_en;
         if (!busy_reg) sck_out <= cpol;
         else if (tick && !at_end) sck_out <= ~sck_out;
      end
   end

   // shared shifter for both roles
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_reg <= `BYTE_ZERO;
         rx_sh_reg <= `BYTE_ZERO;
         sdo_out <= 1'b0;
         bit_reg <= `BIT_ZERO;
         loaded_reg <= 1'b0;
      end else if (load) begin
         loaded_reg <= !mst;
         bit_reg <= `BIT_ZERO;
         // with edge bit set the first bit must lead the first edge
         if (cke) begin
            sdo_out <= load_data[7];
            tx_sh_reg <= {load_data[6:0], 1'b0};
         end else begin
            tx_sh_reg <= load_data;
         end
      end else if (!mst && sel_en && ss_n_s && bit_reg != `BIT_ZERO) begin
         // deselect mid byte drops the partial byte; an idle deselect keeps
         // the loaded byte, else the fifo would drain while unselected
         bit_reg <= `BIT_ZERO;
         loaded_reg <= 1'b0;
      end else begin
         if (do_chg) begin
            sdo_out <= tx_sh_reg[7];
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
         end
         if (do_sample) begin
            rx_sh_reg <= rx_word;
            bit_reg <= bit_reg + 1'b1;
         end
         if (done && !mst) loaded_reg <= 1'b0;
      end
   end

   // receive holding register; a new byte wins over the read clear
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_data_reg <= `BYTE_ZERO;
         rx_full_reg <= 1'b0;
         ovr_reg <= 1'b0;
      end else if (done) begin
         rx_data_reg <= rx_word;
         rx_full_reg <= 1'b1;
         if (rx_full_reg && !rx_read) ovr_reg <= 1'b1;
      end else if (rx_read) begin
         rx_full_reg <= 1'b0;
         ovr_reg <= 1'b0;
      end
   end
endmodule

// File: dv/spi_cfg_checker.sv
// assertion checker for the serial port configuration block
`timescale 1ns/1ps
module spi_cfg_checker (
   input wire clk,
   input wire rst_n,
   input wire [4:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [31:0] readdata,
   input wire waitrequest,
   input wire sck_out,
   input wire sck_oe,
   input wire sck_in,
   input wire sdo_out,
   input wire sdo_oe,
   input wire sdi_in,
   input wire slave_select_pin_n,
   input wire slave_select_pin_owned
);
   reg [15:0] ctrl_q; // shadow of the control word
   reg [1:0] age; // cycles since the last control write, saturating
   // shadow taken control writes; outputs lag so wait for age to settle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= 16'h0000;
         age <= 2'h0;
      end else if (write && waitrequest && address == 5'h00) begin
         ctrl_q <= writedata[15:0];
         age <= 2'h0;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end
   wire st = age[1]; // configuration has reached the pins
   wire mst = st && ctrl_q[5]; // settled master mode
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_wait_one; !waitrequest |=> waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low twice");
   property p_answer; (read || write) && waitrequest && address != 5'h04 |=> !waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_unmap; read && waitrequest && address > 5'h10 |=> readdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_ctrl_rd; read && waitrequest && address == 5'h00 |=> readdata == {19'h0, ctrl_q[12:0]};
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback");
   property p_sck_oe; st |-> sck_oe == ctrl_q[5]; endproperty
   a_sck_oe: assert property (p_sck_oe) else $error("clock drive");
   property p_owned; st |-> slave_select_pin_owned == (!ctrl_q[5] && ctrl_q[7]); endproperty
   a_owned: assert property (p_owned) else $error("select ownership");
   property p_ss_off; (st && !ctrl_q[5] && ctrl_q[7] && slave_select_pin_n) [*4] |-> !sdo_oe;
   endproperty
   a_ss_off: assert property (p_ss_off) else $error("unselected drive");
   property p_idle; (mst && $stable(sck_out)) [*6] |-> sck_out == ctrl_q[6]; endproperty
   a_idle: assert property (p_idle) else $error("idle level");
   property p_edge; mst && $changed(sdo_out) |-> (sck_out == ctrl_q[6]) == ctrl_q[8]; endproperty
   a_edge: assert property (p_edge) else $error("data edge");
   c_master: cover property (mst && $changed(sck_out));
   c_slave: cover property (st && !ctrl_q[5] && !slave_select_pin_n && $changed(sck_in));
   c_rx: cover property (!waitrequest && read && address == 5'h08);
endmodule
bind spi_clock_phase_mode_config spi_cfg_checker chk (.clk, .rst_n, .address, .read, .write,
   .writedata, .readdata, .waitrequest, .sck_out, .sck_oe, .sck_in, .sdo_out, .sdo_oe, .sdi_in,
   .slave_select_pin_n, .slave_select_pin_owned);

// File: dv/spi_peer_model.sv
// far side serial device: clocks frames as master or answers as slave
`timescale 1ns/1ps
module spi_peer_model (
   input wire sck_line,
   input wire sdo_line,
   input wire cpol,
   input wire cke,
   input wire [7:0] tx_byte,
   output reg sck_drv,
   output reg sdi_drv,
   output reg ss_n,
   output reg [7:0] rx_byte
);
   reg [7:0] sh = 8'h00; // outgoing shift register
   initial begin
      sck_drv = 1'b0;
      sdi_drv = 1'b0;
      ss_n = 1'b1;
      rx_byte = 8'h00;
   end
   // sample on one edge kind, change data on the other
   always @(sck_line) begin
      if ((sck_line != cpol) == cke) begin
         rx_byte = {rx_byte[6:0], sdo_line};
      end else begin
         if (cke) sh = sh << 1;
         sdi_drv = sh[7];
         if (!cke) sh = sh << 1;
      end
   end
   // preload; first bit shows early since leading edge may sample it
   task load;
      begin
         sh = tx_byte;
         rx_byte = 8'h00;
         sdi_drv = tx_byte[7];
      end
   endtask
   // one frame at an 800 ns clock, clock still outside it
   task frame;
      begin
         sck_drv = cpol;
         #400 load;
         ss_n = 1'b0;
         repeat (8) begin
            #400 sck_drv = ~cpol;
            #400 sck_drv = cpol;
         end
         #400 ss_n = 1'b1;
         sdi_drv = ~sdi_drv; // released line, not the last value
      end
   endtask
endmodule

// File: dv/tb.sv
// self-checking bench for the serial port configuration block
`timescale 1ns/1ps
module tb;
   reg clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, cpol = 1'b0, cke = 1'b0;
   reg [4:0] address = 5'h00;
   reg [31:0] writedata = 32'h0, q;
   reg [7:0] tx_byte = 8'h00;
   wire [31:0] readdata;
   wire waitrequest, sck_out, sck_oe, sdo_out, sdo_oe, owned, sck_drv, sdi_drv, ss_n;
   wire [7:0] rx_byte;
   wire sck_line = sck_oe ? sck_out : sck_drv; // wire level from both drivers
   integer num_errors = 0, tests_run = 0, i, n;
   always #50 clk = ~clk;
   spi_clock_phase_mode_config dut (.clk, .rst_n, .address, .read, .write, .writedata,
      .readdata, .waitrequest, .sck_out, .sck_oe, .sck_in(sck_line), .sdo_out, .sdo_oe,
      .sdi_in(sdi_drv), .slave_select_pin_n(ss_n), .slave_select_pin_owned(owned));
   spi_peer_model peer (.sck_line, .sdo_line(sdo_out), .cpol, .cke, .tx_byte, .sck_drv,
      .sdi_drv, .ss_n, .rx_byte);
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", tests_run, num_errors);
         if (num_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk(input [47:0] nm, input [31:0] exp, input [31:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch %0s exp %h got %h", nm, exp, got);
         end
      end
   endtask
   // one avalon access held until waitrequest is seen low
   task bus(input w, input [4:0] a, input [31:0] d);
      begin
         read <= !w;
         write <= w;
         address <= a;
         writedata <= d;
         n = 0;
         @(posedge clk);
         while (waitrequest !== 1'b0 && n < 300) begin
            @(posedge clk);
            n = n + 1;
         end
         q = readdata;
         if (n == 300) begin
            chk("wait", 32'h0, 32'h1);
            finish_test;
         end
         read <= 1'b0;
         write <= 1'b0;
         @(posedge clk);
      end
   endtask
   // poll status until the masked bits match, bounded
   task poll(input [31:0] m, input [31:0] v);
      integer k;
      begin
         k = 0;
         bus(1'b0, 5'h0C, 32'h0);
         while ((q & m) !== v && k < 200) begin
            bus(1'b0, 5'h0C, 32'h0);
            k = k + 1;
         end
         if (k == 200) begin
            chk("poll", v, q);
            finish_test;
         end
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, 5'h00, 32'h0);
      chk("ctrl", 32'h0, q);
      bus(1'b0, 5'h10, 32'h0);
      chk("div", 32'h3, q);
      bus(1'b0, 5'h14, 32'h0);
      chk("unmap", 32'h0, q);
      chk("sckoe", 32'h0, {31'h0, sck_oe});
      bus(1'b1, 5'h00, 32'hFFFF);
      bus(1'b0, 5'h00, 32'h0);
      chk("ctrl", 32'h1FFF, q);
      $display("test registers done");
      // master: every polarity, edge and sample phase
      for (i = 0; i < 8; i = i + 1) begin
         cke <= i[1];
         cpol <= i[0];
         tx_byte <= 8'h5A ^ i[7:0];
         bus(1'b1, 5'h00, {22'h0, i[2], i[1], 1'b0, i[0], 1'b1, 5'h00});
         chk("idle", {31'h0, i[0]}, {31'h0, sck_out});
         chk("sckoe", 32'h1, {31'h0, sck_oe});
         peer.load;
         bus(1'b1, 5'h04, {24'h0, 8'hC3 ^ i[7:0]});
         poll(32'h8, 32'h8);
         bus(1'b0, 5'h08, 32'h0);
         chk("rx", {24'h0, 8'h5A ^ i[7:0]}, q);
         chk("peer", {24'h0, 8'hC3 ^ i[7:0]}, {24'h0, rx_byte});
      end
      $display("test master done");
      // fifo fills until a write stalls, then drains with overrun
      for (i = 0; i < 6; i = i + 1)
         bus(1'b1, 5'h04, i);
      bus(1'b0, 5'h0C, 32'h0);
      chk("full", 32'h2, q & 32'h2);
      poll(32'h5, 32'h4);
      chk("stat", 32'h1C, q);
      bus(1'b0, 5'h08, 32'h0);
      bus(1'b0, 5'h0C, 32'h0);
      chk("stat", 32'h4, q);
      $display("test fifo done");
      // slave with select enabled, clocked by the peer
      for (i = 0; i < 4; i = i + 1) begin
         bus(1'b1, 5'h00, {23'h0, i[1], 1'b1, i[0], 1'b0, 5'h00});
         cke <= i[1];
         cpol <= i[0];
         tx_byte <= 8'h96 ^ i[7:0];
         chk("own", 32'h1, {31'h0, owned});
         chk("sdooe", 32'h0, {31'h0, sdo_oe});
         chk("sckoe", 32'h0, {31'h0, sck_oe});
         bus(1'b1, 5'h04, 32'h69);
         bus(1'b1, 5'h04, 32'h69);
         peer.frame;
         peer.frame;
         repeat (8) @(posedge clk);
         bus(1'b0, 5'h08, 32'h0);
         chk("srx", {24'h0, 8'h96 ^ i[7:0]}, q);
         chk("speer", 32'h69, {24'h0, rx_byte});
      end
      bus(1'b1, 5'h00, 32'h0);
      chk("own", 32'h0, {31'h0, owned});
      chk("sdooe", 32'h1, {31'h0, sdo_oe});
      $display("test slave done");
      finish_test;
   end
endmodule
